// ==== core/ipc_top.v ====
// Interrupt priority controller: register set, request banks and CPU priority tie
//
// Behaviour
// R1 - Thirty registers: controls, flags, enables, priorities, capture; the decode maps 33, offsets 0x00-0x20 with status and core control
// R2 - Source sets flag; only software write clears
// R3 - Every source has its own enable bit
// R4 - Software priority field, eight levels per source
// R5 - Capture holds 7-bit vector, 4-bit level
// R6 - Captured level equals presented interrupt priority
// R7 - Banks in vector order, first external first
// R8 - Status bits 7:5 hold writable low priority
// R9 - Fourth priority bit read-only to software
// R10 - CPU priority is fourth bit over low three
// R11 - User interrupts off at msb or 111
// R12 - Nesting disable makes low priority read-only
// R13 - Control one: nesting disable and trap flags
// R14 - Control two: external polarity, alternate table
// R15 - Alternate select bit picks alternate table
// R16 - Polarity set: falling edge, clear: rising
// R17 - Trap flag reads 1 after trap
// R18 - Present highest priority above CPU, lowest vector
// R19 - Capture updates on the request issuing edge
`timescale 1ns/1ps
`default_nettype none
`include "ipc_defines.vh"

module ipc_top (
    // Clock and reset
    input  wire                   sys_clk_i,
    input  wire                   rstn_i,
    // Register port
    input  wire [`IPC_ADDR_W-1:0] addr_i,
    input  wire [`IPC_DATA_W-1:0] wdata_i,
    input  wire                   wr_i,
    input  wire                   rd_i,
    output reg  [`IPC_DATA_W-1:0] rdata_o,
    // Interrupt sources
    input  wire [`IPC_NUM_SRC-1:0] periph_req_i,
    input  wire [4:0]             ext_pin_i,
    input  wire [15:0]            trap_set_i,
    // CPU core side
    input  wire                   irq_ack_i,
    input  wire                   trap_entry_i,
    input  wire                   trap_exit_i,
    output reg                    irq_req_o,
    output reg  [`IPC_VEC_W-1:0]  irq_vector_o,
    output reg  [`IPC_LEVEL_W-1:0] irq_level_o,
    output reg                    alt_table_o,
    output reg  [`IPC_LEVEL_W-1:0] cpu_priority_o
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function in_bank;
        input [`IPC_ADDR_W-1:0] a;
        input [`IPC_ADDR_W-1:0] base;
        input [`IPC_ADDR_W-1:0] cnt;
        begin
            in_bank = (a >= base) && (a < base + cnt);
        end
    endfunction

    function [4:0] bank_idx;
        input [`IPC_ADDR_W-1:0] a;
        input [`IPC_ADDR_W-1:0] base;
        reg   [`IPC_ADDR_W-1:0] d;
        begin
            d        = a - base;
            bank_idx = d[4:0];
        end
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    reg  [15:0]                   ctrl_one_q;
    reg  [15:0]                   ctrl_one_d;
    reg                           alt_table_q;
    reg  [`IPC_EXT_POL_W-1:0]     ext_pol_q;
    reg  [`IPC_NUM_BITS-1:0]      flag_q;
    reg  [`IPC_NUM_BITS-1:0]      flag_d;
    reg  [`IPC_NUM_BITS-1:0]      en_q;
    reg  [`IPC_PRIO_W-1:0]        prio_q [0:`IPC_NUM_SRC-1];
    reg  [`IPC_PRIO_W-1:0]        cpu_priority_low3_q;
    reg                           cpu_priority_msb_q;
    reg  [`IPC_VEC_W-1:0]         pending_vector_number_q;
    reg  [`IPC_LEVEL_W-1:0]       pending_priority_level_q;
    reg  [`IPC_NUM_SRC-1:0]       src_set;
    reg  [15:0]                   rd_d;

    wire [4:0]                    ext_edge;
    wire [`IPC_NUM_SRC*3-1:0]     prio_bus;
    wire [`IPC_NUM_SRC-1:0]       pend;
    wire                          win_found;
    wire [6:0]                    win_index;
    wire [2:0]                    win_level;
    wire                          nesting_disable;
    wire                          user_blocked;
    wire [`IPC_LEVEL_W-1:0]       cpu_level;
    integer                       k;
    integer                       kr;

    assign nesting_disable = ctrl_one_q[`IPC_NEST_DIS_BIT];
    assign cpu_level       = {cpu_priority_msb_q, cpu_priority_low3_q}; // R10
    assign user_blocked    = cpu_priority_msb_q ||
                             (cpu_priority_low3_q == `IPC_LOW3_MAX); // R11
    assign pend            = flag_q[`IPC_NUM_SRC-1:0] & en_q[`IPC_NUM_SRC-1:0]; // R3

    // ****************************************************************
    // External request edges
    // ****************************************************************
    ipc_ext_edge #(
        .N (`IPC_EXT_POL_W)
    ) u_ext_edge (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     (ext_pin_i),
        .falling_i (ext_pol_q),
        .edge_o    (ext_edge)
    );

    // ****************************************************************
    // Priority bank flattened for the arbiter
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < `IPC_NUM_SRC; g = g + 1) begin : g_prio
            assign prio_bus[g*3 +: 3] = prio_q[g];
        end
    endgenerate

    ipc_arbiter #(
        .NSRC (`IPC_NUM_SRC)
    ) u_arbiter (
        .pend_i      (pend),
        .prio_i      (prio_bus),
        .cpu_level_i (cpu_level),
        .found_o     (win_found),
        .index_o     (win_index),
        .level_o     (win_level)
    );

    // ****************************************************************
    // Request flag sources
    // ****************************************************************
    always @* begin
        src_set = periph_req_i;
        src_set[`IPC_IRQ_EXT0] = periph_req_i[`IPC_IRQ_EXT0] | ext_edge[0]; // R7
        src_set[`IPC_IRQ_EXT1] = periph_req_i[`IPC_IRQ_EXT1] | ext_edge[1];
        src_set[`IPC_IRQ_EXT2] = periph_req_i[`IPC_IRQ_EXT2] | ext_edge[2];
        src_set[`IPC_IRQ_EXT3] = periph_req_i[`IPC_IRQ_EXT3] | ext_edge[3];
        src_set[`IPC_IRQ_EXT4] = periph_req_i[`IPC_IRQ_EXT4] | ext_edge[4];
    end

    // ****************************************************************
    // Next flag bank and control one: hardware set wins over write
    // ****************************************************************
    always @* begin
        k      = 0;
        flag_d = flag_q;
        if (wr_i && in_bank(addr_i, `IPC_OFS_FLAG_BASE, `IPC_FLAG_REGS)) begin
            k = bank_idx(addr_i, `IPC_OFS_FLAG_BASE);
            flag_d[k*16 +: 16] = wdata_i; // R2
        end
        flag_d[`IPC_NUM_SRC-1:0] = flag_d[`IPC_NUM_SRC-1:0] | src_set; // R2
        flag_d[`IPC_NUM_BITS-1:`IPC_NUM_SRC] = 8'h00;
    end

    always @* begin
        ctrl_one_d = ctrl_one_q;
        if (wr_i && addr_i == `IPC_OFS_CTRL_ONE) begin
            ctrl_one_d = wdata_i & `IPC_CTRL_ONE_WMASK; // R13
        end
        ctrl_one_d = ctrl_one_d | (trap_set_i & `IPC_CTRL_ONE_WMASK); // R17
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_one_q  <= `IPC_RST_WORD;
            alt_table_q <= 1'b0;
            ext_pol_q   <= 5'h00;
            flag_q      <= 80'h0;
            en_q        <= 80'h0;
        end else begin
            ctrl_one_q <= ctrl_one_d;
            flag_q     <= flag_d;
            if (wr_i && addr_i == `IPC_OFS_CTRL_TWO) begin
                alt_table_q <= wdata_i[`IPC_ALT_TABLE_BIT]; // R14
                ext_pol_q   <= wdata_i[`IPC_EXT_POL_W-1:0]; // R14
            end
            if (wr_i && in_bank(addr_i, `IPC_OFS_EN_BASE, `IPC_EN_REGS)) begin
                en_q[bank_idx(addr_i, `IPC_OFS_EN_BASE)*16 +: 16] <= wdata_i; // R3
            end
            en_q[`IPC_NUM_BITS-1:`IPC_NUM_SRC] <= 8'h00;
        end
    end

    generate
        for (g = 0; g < `IPC_NUM_SRC; g = g + 1) begin : g_prio_reg
            always @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    prio_q[g] <= `IPC_RST_PRIO;
                end else if (wr_i && addr_i == `IPC_OFS_PRIO_BASE + g / `IPC_SRC_PER_PRIO) begin
                    prio_q[g] <= wdata_i[(g % `IPC_SRC_PER_PRIO)*4 +: 3]; // R4
                end
            end
        end
    endgenerate

    // ****************************************************************
    // CPU priority level
    // ****************************************************************
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cpu_priority_low3_q <= 3'h0;
            cpu_priority_msb_q  <= 1'b0;
        end else begin
            if (irq_ack_i) begin
                cpu_priority_low3_q <= pending_priority_level_q[2:0];
            end else if (wr_i && addr_i == `IPC_OFS_STATUS && !nesting_disable) begin // R12
                cpu_priority_low3_q <= wdata_i[`IPC_STATUS_PRIO_LSB +: 3]; // R8
            end
            // Only the core moves the msb; software writes never reach it
            if (trap_entry_i) begin
                cpu_priority_msb_q <= 1'b1; // R9
            end else if (trap_exit_i) begin
                cpu_priority_msb_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Request to the CPU and vector capture
    // ****************************************************************
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_req_o                <= 1'b0;
            pending_vector_number_q  <= 7'h00;
            pending_priority_level_q <= 4'h0;
        end else begin
            irq_req_o <= win_found && !user_blocked && !irq_ack_i; // R11
            if (win_found && !user_blocked && !irq_ack_i) begin
                pending_vector_number_q  <= win_index + `IPC_VEC_OFFSET; // R19
                pending_priority_level_q <= {1'b0, win_level}; // R6
            end
        end
    end

    always @* begin
        irq_vector_o = pending_vector_number_q; // R5
        irq_level_o  = pending_priority_level_q; // R5
    end

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            alt_table_o    <= 1'b0;
            cpu_priority_o <= 4'h0;
        end else begin
            alt_table_o    <= alt_table_q; // R15
            cpu_priority_o <= cpu_level; // R10
        end
    end

    // ****************************************************************
    // Read data, valid only in the cycle after the strobe
    // ****************************************************************
    always @* begin
        kr   = 0;
        rd_d = 16'h0000;
        if (addr_i == `IPC_OFS_CTRL_ONE) begin
            rd_d = ctrl_one_q; // R17
        end else if (addr_i == `IPC_OFS_CTRL_TWO) begin
            rd_d = {alt_table_q, 10'h000, ext_pol_q};
        end else if (in_bank(addr_i, `IPC_OFS_FLAG_BASE, `IPC_FLAG_REGS)) begin
            rd_d = flag_q[bank_idx(addr_i, `IPC_OFS_FLAG_BASE)*16 +: 16];
        end else if (in_bank(addr_i, `IPC_OFS_EN_BASE, `IPC_EN_REGS)) begin
            rd_d = en_q[bank_idx(addr_i, `IPC_OFS_EN_BASE)*16 +: 16];
        end else if (in_bank(addr_i, `IPC_OFS_PRIO_BASE, `IPC_PRIO_REGS)) begin
            kr = bank_idx(addr_i, `IPC_OFS_PRIO_BASE) * `IPC_SRC_PER_PRIO;
            rd_d = {1'b0, prio_q[kr+3], 1'b0, prio_q[kr+2],
                    1'b0, prio_q[kr+1], 1'b0, prio_q[kr]}; // R1
        end else if (addr_i == `IPC_OFS_CAPTURE) begin
            rd_d = {4'h0, pending_priority_level_q, 1'b0, pending_vector_number_q}; // R5
        end else if (addr_i == `IPC_OFS_STATUS) begin
            rd_d = {8'h00, cpu_priority_low3_q, 5'h00}; // R8
        end else if (addr_i == `IPC_OFS_CORE_CTRL) begin
            rd_d = {12'h000, cpu_priority_msb_q, 3'h0}; // R9
        end
    end

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= rd_i ? rd_d : 16'h0000;
        end
    end

endmodule

`default_nettype wire

// ==== common/ipc_defines.vh ====
// Constants for the interrupt priority controller: offsets, fields, reset values
`ifndef IPC_DEFINES_VH
`define IPC_DEFINES_VH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define IPC_ADDR_W          6
`define IPC_DATA_W          16
`define IPC_NUM_REGS        30

// ****************************************************************
// Register offsets (word index on the register port)
// ****************************************************************
`define IPC_OFS_CTRL_ONE    6'h00
`define IPC_OFS_CTRL_TWO    6'h01
`define IPC_OFS_FLAG_BASE   6'h02
`define IPC_OFS_EN_BASE     6'h07
`define IPC_OFS_PRIO_BASE   6'h0C
`define IPC_OFS_CAPTURE     6'h1E
`define IPC_OFS_STATUS      6'h1F
`define IPC_OFS_CORE_CTRL   6'h20

// ****************************************************************
// Bank sizes
// ****************************************************************
`define IPC_FLAG_REGS       5
`define IPC_EN_REGS         5
`define IPC_PRIO_REGS       18
`define IPC_SRC_PER_PRIO    4
`define IPC_NUM_SRC         72
`define IPC_NUM_BITS        80
`define IPC_VEC_OFFSET      7'h08

// ****************************************************************
// Field positions
// ****************************************************************
`define IPC_NEST_DIS_BIT    15
`define IPC_CTRL_ONE_WMASK  16'hFFFE
`define IPC_ALT_TABLE_BIT   15
`define IPC_EXT_POL_W       5
`define IPC_STATUS_PRIO_LSB 5
`define IPC_CORE_PRIO_BIT   3
`define IPC_PRIO_W          3
`define IPC_LEVEL_W         4
`define IPC_VEC_W           7
`define IPC_CAP_LEVEL_LSB   8
`define IPC_LOW3_MAX        3'h7

// ****************************************************************
// External request source positions (request index)
// ****************************************************************
`define IPC_IRQ_EXT0        0
`define IPC_IRQ_EXT1        13
`define IPC_IRQ_EXT2        29
`define IPC_IRQ_EXT3        53
`define IPC_IRQ_EXT4        54

// ****************************************************************
// Reset values
// ****************************************************************
`define IPC_RST_WORD        16'h0000
`define IPC_RST_PRIO        3'h0

`endif

// ==== core/ipc_ext_edge.v ====
// External request pins: two-stage synchroniser and polarity-selected edge detect
`timescale 1ns/1ps
`default_nettype none

module ipc_ext_edge #(
    parameter N = 5
) (
    // Clock and reset
    input  wire         sys_clk_i,
    input  wire         rstn_i,
    // Pins and polarity
    input  wire [N-1:0] pin_i,
    input  wire [N-1:0] falling_i,
    // Edge pulses
    output reg  [N-1:0] edge_o
);

    reg [N-1:0] meta_q;
    reg [N-1:0] sync_q;
    reg [N-1:0] prev_q;

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_pin
            always @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                    prev_q[g] <= 1'b0;
                    edge_o[g] <= 1'b0;
                end else begin
                    meta_q[g] <= pin_i[g];
                    sync_q[g] <= meta_q[g];
                    prev_q[g] <= sync_q[g];
                    // Set polarity: falling edge, clear: rising edge
                    edge_o[g] <= falling_i[g] ? (prev_q[g] & ~sync_q[g])
                                              : (~prev_q[g] & sync_q[g]); // R16
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ==== core/ipc_arbiter.v ====
// Priority arbiter: picks the highest pending source above the CPU level
`timescale 1ns/1ps
`default_nettype none

module ipc_arbiter #(
    parameter NSRC = 72
) (
    // Candidates
    input  wire [NSRC-1:0]   pend_i,
    input  wire [NSRC*3-1:0] prio_i,
    input  wire [3:0]        cpu_level_i,
    // Winner
    output reg               found_o,
    output reg  [6:0]        index_o,
    output reg  [2:0]        level_o
);

    integer i;

    always @* begin
        found_o = 1'b0;
        index_o = 7'h00;
        level_o = 3'h0;
        for (i = 0; i < NSRC; i = i + 1) begin
            // Strictly greater keeps the lower index on a tie
            if (pend_i[i] && ({1'b0, prio_i[i*3 +: 3]} > cpu_level_i) &&
                (!found_o || prio_i[i*3 +: 3] > level_o)) begin // R18
                found_o = 1'b1;
                index_o = i[6:0];
                level_o = prio_i[i*3 +: 3];
            end
        end
    end

endmodule

`default_nettype wire

// ==== bench/ipc_top_assertions.sv ====
// Port-level checks for the interrupt priority controller
`timescale 1ns/1ps
`default_nettype none
module ipc_top_assertions (
    // Clock and reset
    input wire logic        sys_clk_i,
    input wire logic        rstn_i,
    // Register port
    input wire logic [5:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    // CPU side
    input wire logic        irq_ack_i,
    input wire logic        trap_entry_i,
    input wire logic        trap_exit_i,
    input wire logic        irq_req_o,
    input wire logic [6:0]  irq_vector_o,
    input wire logic [3:0]  irq_level_o,
    input wire logic        alt_table_o,
    input wire logic [3:0]  cpu_priority_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_rd_idle;
        !rd_i |=> rdata_o == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
    property p_unmapped;
        rd_i && addr_i > 6'h20 |=> rdata_o == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ack_drop;
        irq_ack_i && irq_req_o |=> !irq_req_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("request held after accept");
    property p_ack_level;
        irq_ack_i && irq_req_o && !wr_i |=> ##1 cpu_priority_o[2:0] == $past(irq_level_o[2:0], 2);
    endproperty
    a_ack_level: assert property (p_ack_level) else $error("cpu level not taken from capture");
    property p_level_ok;
        irq_req_o |-> irq_level_o[3] == 1'b0 && irq_level_o != 4'h0;
    endproperty
    a_level_ok: assert property (p_level_ok) else $error("presented level out of range");
    property p_vec_range;
        irq_req_o |-> irq_vector_o >= 7'h08 && irq_vector_o <= 7'h4F;
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("vector outside user range");
    property p_blocked;
        cpu_priority_o[3] || cpu_priority_o[2:0] == 3'h7 |-> !irq_req_o;
    endproperty
    a_blocked: assert property (p_blocked) else $error("request while user interrupts off");
    property p_trap_in;
        trap_entry_i |=> ##1 cpu_priority_o[3];
    endproperty
    a_trap_in: assert property (p_trap_in) else $error("trap entry did not raise msb");
    property p_trap_out;
        trap_exit_i && !trap_entry_i |=> ##1 !cpu_priority_o[3];
    endproperty
    a_trap_out: assert property (p_trap_out) else $error("trap exit did not clear msb");
    property p_core_ro;
        wr_i && addr_i == 6'h20 && !trap_entry_i && !trap_exit_i |=> ##1 $stable(cpu_priority_o[3]);
    endproperty
    a_core_ro: assert property (p_core_ro) else $error("software moved the msb");
    property p_alt;
        wr_i && addr_i == 6'h01 |=> ##1 alt_table_o == $past(wdata_i[15], 2);
    endproperty
    a_alt: assert property (p_alt) else $error("alternate table select not followed");
    c_accept: cover property (irq_ack_i && irq_req_o);
    c_trap: cover property (cpu_priority_o[3]);
    c_top: cover property (cpu_priority_o[2:0] == 3'h7);
endmodule
bind ipc_top ipc_top_assertions u_chk (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_ack_i(irq_ack_i),
    .trap_entry_i(trap_entry_i), .trap_exit_i(trap_exit_i), .irq_req_o(irq_req_o),
    .irq_vector_o(irq_vector_o), .irq_level_o(irq_level_o), .alt_table_o(alt_table_o),
    .cpu_priority_o(cpu_priority_o)
);
`default_nettype wire

// ==== bench/ipc_cpu_model.sv ====
// CPU core model: accepts presented interrupts, enters and leaves traps
`timescale 1ns/1ps
`default_nettype none
module ipc_cpu_model (
    // Clock and reset
    input wire logic       sys_clk_i,
    input wire logic       rstn_i,
    // Bench commands
    input wire logic [1:0] delay_i,
    input wire logic       enter_i,
    input wire logic       leave_i,
    // Controller side
    input wire logic       irq_req_i,
    output logic           irq_ack_o,
    output logic           trap_entry_o,
    output logic           trap_exit_o
);
    logic [1:0] wait_q;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_q       <= 2'h0;
            irq_ack_o    <= 1'b0;
            trap_entry_o <= 1'b0;
            trap_exit_o  <= 1'b0;
        end else begin
            trap_entry_o <= enter_i;
            trap_exit_o  <= leave_i;
            // One accept per presentation, after a chosen wait
            if (irq_ack_o || !irq_req_i) begin
                irq_ack_o <= 1'b0;
                wait_q    <= 2'h0;
            end else if (wait_q == delay_i) begin
                irq_ack_o <= 1'b1;
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/test_interrupt_priority_control.sv ====
// Self-checking testbench for the interrupt priority controller
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_priority_control;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [5:0]  addr = 6'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [71:0] periph = '0;
    logic [4:0]  ext_pin = 5'h00;
    logic [15:0] trap_set = 16'h0000;
    logic [1:0]  delay = 2'h0;
    logic        enter = 1'b0;
    logic        leave = 1'b0;
    logic        rd_d = 1'b0;
    logic        irq_d = 1'b0;
    wire  [15:0] rdata;
    wire         ack, t_in, t_out, irq, alt;
    wire  [6:0]  vec;
    wire  [3:0]  lvl, cpu_prio;
    logic [15:0] rd_q[$];
    logic [15:0] irq_q[$];
    logic [15:0] tv;
    int          n_fail = 0;
    int          checks_done = 0;
    int          s;
    int          lv;
    int          i;
    always #4 clk = ~clk;
    ipc_top dut (
        .sys_clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .periph_req_i(periph), .ext_pin_i(ext_pin), .trap_set_i(trap_set),
        .irq_ack_i(ack), .trap_entry_i(t_in), .trap_exit_i(t_out), .irq_req_o(irq),
        .irq_vector_o(vec), .irq_level_o(lvl), .alt_table_o(alt), .cpu_priority_o(cpu_prio)
    );
    ipc_cpu_model u_cpu (
        .sys_clk_i(clk), .rstn_i(rstn), .delay_i(delay), .enter_i(enter), .leave_i(leave),
        .irq_req_i(irq), .irq_ack_o(ack), .trap_entry_o(t_in), .trap_exit_o(t_out)
    );
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Result watcher: read data and new presentations
    always @(posedge clk) begin
        if (rd_d) chk(rdata, rd_q.pop_front());
        if (irq && !irq_d) chk({5'h00, vec, lvl}, (irq_q.size() > 0) ? irq_q.pop_front() : 16'hFFFF);
        rd_d  <= rd;
        irq_d <= irq;
    end
    task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [5:0] a, input logic [15:0] e);
        rd_q.push_back(e);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
    endtask
    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        periph <= '0;
        enter <= 1'b0;
        leave <= 1'b0;
        trap_set <= 16'h0000;
        repeat (n) @(posedge clk);
    endtask
    task automatic pulse(input int a, input int b);
        periph <= (72'h1 << a) | (72'h1 << b);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
        idle(12);
    endtask
    task automatic cfg(input int src, input int lev);
        wr_reg(6'(7 + src / 16), 16'(1 << (src % 16)));
        wr_reg(6'(12 + src / 4), 16'(lev << (4 * (src % 4))));
    endtask
    task automatic clr(input int src);
        wr_reg(6'(2 + src / 16), 16'h0000);
        wr_reg(6'(7 + src / 16), 16'h0000);
        wr_reg(6'(12 + src / 4), 16'h0000);
    endtask
    task automatic expect_irq(input int src, input int lev);
        irq_q.push_back({5'h00, 7'(src + 8), 4'(lev)});
    endtask
    initial begin
        #400000;
        n_fail++;
        final_report();
    end
    initial begin
        void'($urandom(32'hA7AB));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 34; i++) rd_reg(6'(i), 16'h0000);
        rd_reg(6'h3F, 16'h0000);
        wr_reg(6'h00, 16'hFFFF);
        rd_reg(6'h00, 16'hFFFE);
        wr_reg(6'h00, 16'h0000);
        wr_reg(6'h01, 16'hFFFF);
        rd_reg(6'h01, 16'h801F);
        wr_reg(6'h0B, 16'hFFFF);
        rd_reg(6'h0B, 16'h00FF);
        wr_reg(6'h1D, 16'hFFFF);
        rd_reg(6'h1D, 16'h7777);
        wr_reg(6'h0B, 16'h0000);
        wr_reg(6'h1D, 16'h0000);
        wr_reg(6'h30, 16'hFFFF);
        rd_reg(6'h30, 16'h0000);
        wr_reg(6'h01, 16'h0001);
        tv = 16'($urandom()) & 16'h7FFE;
        trap_set <= tv;
        wr <= 1'b0;
        @(posedge clk);
        idle(2);
        rd_reg(6'h00, tv);
        wr_reg(6'h00, 16'h0000);
        for (i = 0; i < 6; i++) begin
            s = $urandom_range(71, 1);
            lv = $urandom_range(7, 1);
            delay <= 2'($urandom_range(3, 0));
            cfg(s, lv);
            expect_irq(s, lv);
            pulse(s, s);
            chk({12'h000, cpu_prio}, 16'(lv));
            rd_reg(6'(2 + s / 16), 16'(1 << (s % 16)));
            rd_reg(6'h1E, {4'h0, 4'(lv), 1'b0, 7'(s + 8)});
            clr(s);
            wr_reg(6'h1F, 16'h0000);
        end
        cfg(3, 5);
        cfg(20, 5);
        expect_irq(3, 5);
        pulse(3, 20);
        clr(3);
        clr(20);
        wr_reg(6'h1F, 16'h0000);
        cfg(3, 4);
        cfg(40, 6);
        expect_irq(40, 6);
        pulse(3, 40);
        clr(3);
        clr(40);
        wr_reg(6'h1F, 16'h00E0);
        rd_reg(6'h1F, 16'h00E0);
        cfg(30, 7);
        pulse(30, 30);
        chk({12'h000, cpu_prio}, 16'h0007);
        wr_reg(6'h00, 16'h8000);
        wr_reg(6'h1F, 16'h0000);
        rd_reg(6'h1F, 16'h00E0);
        wr_reg(6'h00, 16'h0000);
        enter <= 1'b1;
        wr <= 1'b0;
        @(posedge clk);
        idle(4);
        chk({12'h000, cpu_prio}, 16'h000F);
        wr_reg(6'h20, 16'h0000);
        rd_reg(6'h20, 16'h0008);
        wr_reg(6'h1F, 16'h0000);
        idle(6);
        expect_irq(30, 7);
        leave <= 1'b1;
        wr <= 1'b0;
        @(posedge clk);
        idle(12);
        clr(30);
        wr_reg(6'h1F, 16'h0000);
        cfg(0, 2);
        ext_pin[0] <= 1'b1;
        idle(8);
        rd_reg(6'h02, 16'h0000);
        expect_irq(0, 2);
        ext_pin[0] <= 1'b0;
        idle(14);
        clr(0);
        idle(4);
        chk(16'(irq_q.size()), 16'h0000);
        final_report();
    end
endmodule
`default_nettype wire
